// [design/vectored_interrupt_control.sv]
// Interrupt controller: encodes seven level requests and answers acks.
// Assumes the processor end holds level and decode stable per cycle.
//
// Overview of operation
// RULE1 - Levels map to parallel, bus, floppy, bus, serial, timer, NMI
// RULE2 - Seven active-low requests feed priority encoder
// RULE3 - Processor acks only above its mask; level 7 is acked at any mask
// RULE4 - Processor puts acked level on address
// RULE5 - Levels 1,3,5,6,7 always autovector
// RULE6 - Levels 2,4 autovector only on bus request
// RULE7 - Autovector forms vector; times four addresses
// RULE8 - Bus-vectored levels get vector from peripheral
// RULE9 - Autovector only during acknowledge function decode
// RULE10 - Separate ack strobes for levels 3,5,7
// RULE11 - Level 5/7 acks form transfer ack pair
// RULE12 - Ack decoder enabled only during decode
// RULE13 - Power-on reset raises level 7 request
// RULE14 - Power-fail warning raises level 7 request
// RULE15 - Parity error latches level 7 request
// RULE16 - Highest active level wins; none negates
`timescale 1ns/10ps
module vectored_interrupt_control
   import irq_ctl_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       clk_en,
   // Level request inputs, active low
   input  wire logic       parallel_irq_n,
   input  wire logic       bus_irq2_n,
   input  wire logic       floppy_irq_n,
   input  wire logic       bus_irq4_n,
   input  wire logic       serial_irq_n,
   input  wire logic       timer_irq_n,
   // Level 7 sources
   input  wire logic       power_fail_warn,
   input  wire logic       parity_irq_n,
   // I/O bus vectoring request
   input  wire logic       bus_autovec_req_n,
   // Processor side
   irq_ack_if.ctrl         cpu,
   // Acknowledge strobes
   output logic            ack_lvl3_n,
   output logic            ack_lvl5_n,
   output logic            ack_lvl7_n
);

////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic       por_pend;
      logic       parity_pend;
      logic [2:0] prio_n;
      logic       avec_n;
      logic       ack3_n;
      logic       ack5_n;
      logic       ack7_n;
      logic       req_ack;
   } state_s;

   state_s     st_reg;
   state_s     st_next;
   logic [6:0] req_n;
   logic [2:0] top_lvl;
   logic       in_ack;
   logic       lvl3_hit;
   logic       lvl5_hit;
   logic       lvl7_hit;

   // RULE12 decoder gated by decode
   assign in_ack = !cpu.ack_cycle_decode_n;

   // RULE10 one decoder output per strobed level (3, 5, 7)
   // Shared by strobes, pending clears and the requester pair,
   // so all of them agree on which level was acknowledged
   ack_level_match #(.MATCH_LVL(LVL_FLOPPY)) lvl3_match_inst
   (
      .in_ack (in_ack),
      .level  (cpu.ack_level),
      .hit    (lvl3_hit)
   );
   ack_level_match #(.MATCH_LVL(LVL_SERIAL)) lvl5_match_inst
   (
      .in_ack (in_ack),
      .level  (cpu.ack_level),
      .hit    (lvl5_hit)
   );
   ack_level_match #(.MATCH_LVL(LVL_NMI)) lvl7_match_inst
   (
      .in_ack (in_ack),
      .level  (cpu.ack_level),
      .hit    (lvl7_hit)
   );

////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      st_next = st_reg;
      // RULE1 source to level map
      req_n   = {1'b1, timer_irq_n, serial_irq_n, bus_irq4_n,
                 floppy_irq_n, bus_irq2_n, parallel_irq_n};
      // RULE14 power fail on NMI
      // RULE13 power-on pending on NMI
      // RULE15 parity latch on NMI
      req_n[REQ_NMI_BIT] = !(power_fail_warn || st_reg.por_pend ||
                             st_reg.parity_pend);
      // RULE2 priority encoder
      // RULE16 highest level wins
      top_lvl = LVL_NONE;
      for (int i = 0; i < NUM_LEVELS; i++)
      begin
         if (!req_n[i])
         begin
            top_lvl = LEVEL_W'(i + 1);
         end
      end
      st_next.prio_n = ~top_lvl;
      // RULE15 latch until level 7 ack; a new error wins
      if (!parity_irq_n)
      begin
         st_next.parity_pend = 1'b1;
      end
      else if (lvl7_hit)
      begin
         st_next.parity_pend = 1'b0;
      end
      // RULE13 cleared by first level 7 ack
      if (lvl7_hit)
      begin
         st_next.por_pend = 1'b0;
      end
      // RULE9 selector gated by decode
      st_next.avec_n = 1'b1;
      if (in_ack)
      begin
         unique case (cpu.ack_level)
            // RULE6 bus levels conditional
            LVL_BUS_A, LVL_BUS_B:
            begin
               st_next.avec_n = bus_autovec_req_n;
            end
            // RULE5 always autovectored
            LVL_PARALLEL, LVL_FLOPPY, LVL_SERIAL, LVL_TIMER, LVL_NMI:
            begin
               st_next.avec_n = 1'b0;
            end
            // Level zero is never acknowledged
            default:
            begin
               st_next.avec_n = 1'b1;
            end
         endcase
      end
      // RULE10 level strobes
      st_next.ack3_n  = !lvl3_hit;
      st_next.ack5_n  = !lvl5_hit;
      st_next.ack7_n  = !lvl7_hit;
      // RULE11 requester ack pair
      st_next.req_ack = lvl5_hit || lvl7_hit;
   end

////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         // RULE13 reset raises NMI
         st_reg <= '{por_pend:    1'b1,
                     parity_pend: 1'b0,
                     prio_n:      ~LVL_NONE,
                     avec_n:      1'b1,
                     ack3_n:      1'b1,
                     ack5_n:      1'b1,
                     ack7_n:      1'b1,
                     req_ack:     1'b0};
      end
      else if (clk_en)
      begin
         st_reg <= st_next;
      end
   end

////////////////////////////////////////////////////////////////////////////
   assign cpu.cpu_priority_n    = st_reg.prio_n;
   assign cpu.autovector_resp_n = st_reg.avec_n;
   // RULE11 true sense gives transfer ack
   assign cpu.requester_ack     = st_reg.req_ack;
   assign cpu.cpu_xfer_ack_n    = !st_reg.req_ack;
   assign cpu.requester_dir_n   = !st_reg.req_ack;
   assign ack_lvl3_n            = st_reg.ack3_n;
   assign ack_lvl5_n            = st_reg.ack5_n;
   assign ack_lvl7_n            = st_reg.ack7_n;
endmodule

////////////////////////////////////////////////////////////////////////////
// One acknowledge decoder output, one instance for each of the three level strobes
module ack_level_match
   import irq_ctl_pkg::*;
#(
   parameter logic [2:0] MATCH_LVL = LVL_NMI
)
(
   // Decode inputs
   input  wire logic       in_ack,
   input  wire logic [2:0] level,
   // Match output
   output logic            hit
);
   // Plain gate: the controller registers it in its own state
   assign hit = in_ack && level == MATCH_LVL;
endmodule

// [design/irq_ctl_pkg.sv]
// Shared constants for the interrupt control block and its processor end.
// Assumes both ends run on one 250 MHz clock with synchronous inputs.
package irq_ctl_pkg;
   localparam int unsigned NUM_LEVELS     = 7;
   localparam int unsigned LEVEL_W        = 3;
   localparam logic [2:0]  LVL_NONE       = 3'h0;
   localparam logic [2:0]  LVL_PARALLEL   = 3'h1;
   localparam logic [2:0]  LVL_BUS_A      = 3'h2;
   localparam logic [2:0]  LVL_FLOPPY     = 3'h3;
   localparam logic [2:0]  LVL_BUS_B      = 3'h4;
   localparam logic [2:0]  LVL_SERIAL     = 3'h5;
   localparam logic [2:0]  LVL_TIMER      = 3'h6;
   localparam logic [2:0]  LVL_NMI        = 3'h7;
   // Bit i of the request vector is level i+1
   localparam int unsigned REQ_NMI_BIT    = 6;
   localparam logic [6:0]  REQ_IDLE_N     = 7'h7F;
   localparam int unsigned VECTOR_W       = 8;
   localparam int unsigned AUTOVEC_BASE   = 24;
   localparam int unsigned VEC_ADDR_SCALE = 4;
   localparam logic [7:0]  VECTOR_RESET   = 8'h00;
endpackage

// [design/irq_ack_if.sv]
// Interface joining the interrupt controller and the processor end.
// Assumes a single clock supplied by the bench.
`timescale 1ns/10ps
interface irq_ack_if;
   import irq_ctl_pkg::*;
   logic [2:0] cpu_priority_n;
   logic       ack_cycle_decode_n;
   logic [2:0] ack_level;
   logic       autovector_resp_n;
   logic       cpu_xfer_ack_n;
   logic       requester_ack;
   logic       requester_dir_n;
   modport ctrl
   (
      output cpu_priority_n,
      input  ack_cycle_decode_n,
      input  ack_level,
      output autovector_resp_n,
      output cpu_xfer_ack_n,
      output requester_ack,
      output requester_dir_n
   );
   modport cpu
   (
      input  cpu_priority_n,
      output ack_cycle_decode_n,
      output ack_level,
      input  autovector_resp_n,
      input  cpu_xfer_ack_n,
      input  requester_ack,
      input  requester_dir_n
   );
endinterface

// [design/irq_cpu_end.sv]
// Processor end: watches the priority lines, runs acknowledge cycles.
// Assumes the controller answers one cycle after the level is shown.
`timescale 1ns/10ps
module irq_cpu_end
   import irq_ctl_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Processor mask and bus-vectored data
   input  wire logic [2:0]  cpu_mask,
   input  wire logic [7:0]  bus_vector,
   // Controller side
   irq_ack_if.cpu           ctl,
   // Results
   output logic             vector_valid,
   output logic [7:0]       vector_num,
   output logic [9:0]       handler_ptr_addr
);

////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {IDLE, ACK, RESP, DONE} phase_e;
   typedef struct packed {
      phase_e     phase;
      logic [2:0] lvl;
      logic       valid;
      logic [7:0] vec;
   } cpu_s;

   cpu_s       st_reg;
   cpu_s       st_next;
   logic [2:0] req_lvl;

   always_comb
   begin
      st_next = st_reg;
      req_lvl = ~ctl.cpu_priority_n;
      st_next.valid = 1'b0;
      unique case (st_reg.phase)
         IDLE:
         begin
            // RULE3 only above mask, NMI always
            if (req_lvl != LVL_NONE &&
                (req_lvl > cpu_mask || req_lvl == LVL_NMI))
            begin
               st_next.lvl   = req_lvl;
               st_next.phase = ACK;
            end
         end
         ACK:
         begin
            // Controller registers its answer at the end of this cycle
            st_next.phase = RESP;
         end
         RESP:
         begin
            // RULE7 autovector from level
            if (!ctl.autovector_resp_n)
            begin
               st_next.vec = VECTOR_W'(AUTOVEC_BASE) + {5'h00, st_reg.lvl};
            end
            // RULE8 peripheral supplies vector
            else
            begin
               st_next.vec = bus_vector;
            end
            st_next.valid = 1'b1;
            st_next.phase = DONE;
         end
         DONE:
         begin
            st_next.phase = IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '{phase: IDLE, lvl: 3'h0, valid: 1'b0, vec: VECTOR_RESET};
      end
      else if (clk_en)
      begin
         st_reg <= st_next;
      end
   end

   // RULE4 level on low address
   assign ctl.ack_level          = st_reg.lvl;
   assign ctl.ack_cycle_decode_n = !(st_reg.phase == ACK);
   assign vector_valid           = st_reg.valid;
   assign vector_num             = st_reg.vec;
   // RULE7 vector times four
   assign handler_ptr_addr       = {st_reg.vec, 2'h0};
endmodule

// [testbench/irq_ctl_asserts.sv]
// Checker on the acknowledge interface between the two ends.
// Assumes clk_en stays high while an acknowledge is in flight.
`timescale 1ns/10ps
module irq_ctl_asserts
(
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst,
   // Interface signals
   input wire logic [2:0] cpu_priority_n,
   input wire logic       ack_cycle_decode_n,
   input wire logic [2:0] ack_level,
   input wire logic       autovector_resp_n,
   input wire logic       cpu_xfer_ack_n,
   input wire logic       requester_ack,
   input wire logic       requester_dir_n
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////
   a_avec_fixed_lvls: assert property (
      !ack_cycle_decode_n && ack_level inside {3'h1, 3'h3, 3'h5, 3'h6, 3'h7}
      |=> !autovector_resp_n) else $error("autovector missing");
   a_avec_no_decode: assert property (
      ack_cycle_decode_n |=> autovector_resp_n)
      else $error("autovector outside ack cycle");
   a_rack_set: assert property (
      !ack_cycle_decode_n && ack_level inside {3'h5, 3'h7}
      |=> requester_ack) else $error("requester ack missing");
   a_rack_clear: assert property (
      ack_cycle_decode_n || !(ack_level inside {3'h5, 3'h7})
      |=> !requester_ack) else $error("requester ack spurious");
   a_pair_sense: assert property (
      requester_dir_n != requester_ack && cpu_xfer_ack_n != requester_ack)
      else $error("requester pair senses wrong");
   a_ack_one_cycle: assert property (
      !ack_cycle_decode_n |=> ack_cycle_decode_n)
      else $error("ack phase too long");
   a_ack_level_src: assert property (
      $fell(ack_cycle_decode_n) |-> ack_level == ~$past(cpu_priority_n)
      && ack_level != 3'h0) else $error("ack level not the request");
   a_por_level7: assert property (
      $fell(rst) |-> ##[0:2] cpu_priority_n == 3'h0)
      else $error("no level 7 after reset");
endmodule

// [testbench/tb.sv]
// Bench joining both ends; drives the user sides and judges results.
// Assumes package and interface compiled first; clk_en low only at rest.
`timescale 1ns/10ps
module tb;
   import irq_ctl_pkg::*;
   localparam logic [7:0] BUS_VEC = 8'hA5;
   logic       clock = 1'b0;
   logic       ce = 1'b1;
   logic       rst = 1'b1;
   logic [5:0] req_n = 6'h3F;
   logic       pfw = 1'b0;
   logic       par_n = 1'b1;
   logic       avr_n = 1'b1;
   logic [2:0] mask = 3'h7;
   logic       l3_n, l5_n, l7_n, vv, s_av, s3, s5, s7, s_ra;
   logic [7:0] vnum;
   logic [9:0] hptr;
   int         failures = 0;
   int         n_checks = 0;
   irq_ack_if  link ();
   always #2 clock = ~clock;
   ////////////////////////////////////////////////////////////////////
   vectored_interrupt_control vectored_interrupt_control_inst
   (
      .clock(clock), .rst(rst), .clk_en(ce), .parallel_irq_n(req_n[0]),
      .bus_irq2_n(req_n[1]), .floppy_irq_n(req_n[2]),
      .bus_irq4_n(req_n[3]), .serial_irq_n(req_n[4]),
      .timer_irq_n(req_n[5]), .power_fail_warn(pfw),
      .parity_irq_n(par_n), .bus_autovec_req_n(avr_n), .cpu(link),
      .ack_lvl3_n(l3_n), .ack_lvl5_n(l5_n), .ack_lvl7_n(l7_n)
   );
   irq_cpu_end irq_cpu_end_inst
   (
      .clock(clock), .rst(rst), .clk_en(ce), .cpu_mask(mask),
      .bus_vector(BUS_VEC), .ctl(link), .vector_valid(vv),
      .vector_num(vnum), .handler_ptr_addr(hptr)
   );
   irq_ctl_asserts irq_ctl_asserts_inst
   (
      .clock(clock), .rst(rst), .cpu_priority_n(link.cpu_priority_n),
      .ack_cycle_decode_n(link.ack_cycle_decode_n),
      .ack_level(link.ack_level),
      .autovector_resp_n(link.autovector_resp_n),
      .cpu_xfer_ack_n(link.cpu_xfer_ack_n),
      .requester_ack(link.requester_ack),
      .requester_dir_n(link.requester_dir_n)
   );
   ////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_val(string name, logic [9:0] exp, logic [9:0] got);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Strobes are one-cycle, so they are gathered at every falling edge;
   // sources drop after the ack cycle, else a held level is acked again
   task automatic wait_vec(logic [4:0] exp, logic [7:0] vec);
      logic rel;
      rel = 1'b0;
      {s_av, s3, s5, s7, s_ra} = 5'h00;
      for (int i = 0; i < 20 && vv !== 1'b1; i++)
      begin
         @(posedge clock);
         if (rel)
         begin
            req_n <= 6'h3F;
            mask <= 3'h7;
            pfw <= 1'b0;
         end
         @(negedge clock);
         if (link.ack_cycle_decode_n === 1'b0)
            rel = 1'b1;
         s_av = s_av | ~link.autovector_resp_n;
         {s3, s5, s7} = {s3, s5, s7} | ~{l3_n, l5_n, l7_n};
         s_ra = s_ra | link.requester_ack;
      end
      if (vv !== 1'b1)
      begin
         failures++;
         print_verdict();
      end
      chk_val("vector", {2'h0, vec}, {2'h0, vnum});
      chk_val("handler", {vec, 2'h0}, hptr);
      chk_val("acks", {5'h00, exp}, {5'h00, s_av, s3, s5, s7, s_ra});
      repeat (4) @(posedge clock);
   endtask
   task automatic encode;
      for (int l = 1; l <= 6; l++)
      begin
         @(posedge clock);
         req_n <= ~(6'h01 | (6'h01 << (l - 1)));
         repeat (2) @(negedge clock);
         chk_val("prio", {7'h00, ~3'(l)}, link.cpu_priority_n);
      end
      @(posedge clock);
      req_n <= 6'h3F;
      repeat (2) @(negedge clock);
      chk_val("idle", 10'h007, link.cpu_priority_n);
   endtask
   // Clock enable low must hold the priority outputs, then release them
   task automatic freeze;
      @(posedge clock);
      ce <= 1'b0;
      req_n <= 6'h1F;
      repeat (3) @(negedge clock);
      chk_val("frozen", 10'h007, link.cpu_priority_n);
      @(posedge clock);
      ce <= 1'b1;
      repeat (2) @(negedge clock);
      chk_val("thawed", 10'h001, link.cpu_priority_n);
      @(posedge clock);
      req_n <= 6'h3F;
      repeat (2) @(negedge clock);
   endtask
   task automatic svc(int lvl, logic avr);
      @(posedge clock);
      mask <= 3'h0;
      avr_n <= avr;
      req_n[lvl-1] <= 1'b0;
      wait_vec({!(lvl inside {2, 4}) || !avr, lvl == 3, lvl == 5, 1'b0,
                lvl == 5}, (!(lvl inside {2, 4}) || !avr) ?
               8'(AUTOVEC_BASE + lvl) : BUS_VEC);
   endtask
   task automatic nmi;
      @(posedge clock);
      pfw <= 1'b1;
      req_n <= 6'h3B;
      wait_vec(5'h13, 8'(AUTOVEC_BASE + LVL_NMI));
      req_n <= 6'h3B;
      repeat (2) @(negedge clock);
      chk_val("low", 10'h004, link.cpu_priority_n);
      @(posedge clock);
      req_n <= 6'h3F;
      par_n <= 1'b0;
      @(posedge clock);
      par_n <= 1'b1;
      wait_vec(5'h13, 8'(AUTOVEC_BASE + LVL_NMI));
      @(negedge clock);
      chk_val("clear", 10'h007, link.cpu_priority_n);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      wait_vec(5'h13, 8'(AUTOVEC_BASE + LVL_NMI));
      encode();
      freeze();
      for (int l = 1; l <= 6; l++)
         svc(l, 1'b1);
      svc(2, 1'b0);
      svc(4, 1'b0);
      nmi();
      print_verdict();
   end
endmodule
